/* shared/spim_consts.svh */
`ifndef SPIM_CONSTS_SVH
`define SPIM_CONSTS_SVH
`define SPIM_WORD_W 32
`define SPIM_ADDR_W 24
`define SPIM_CNT_W 16
`define SPIM_FIFO_DEPTH 8
`define SPIM_FIFO_AW 3
`define SPIM_CAP8 4'h8
`define SPIM_CAP16 4'h4
`define SPIM_CAP32 4'h2
`define SPIM_BITS8 6'h08
`define SPIM_BITS16 6'h10
`define SPIM_BITS32 6'h20
`define SPIM_CMD_RD 8'h03
`define SPIM_CMD_FAST 8'h0B
`define SPIM_CMD_DUAL 8'h3B
`define SPIM_CMD_QUAD 8'h6B
`define SPIM_HDR_CLKS 6'h20
`define SPIM_DUMMY_CLKS 6'h08
`define SPIM_HALF_MIN 5'h02
`define SPIM_OE_1 4'h1
`define SPIM_OE_2 4'h3
`define SPIM_OE_4 4'hF
`endif

/* shared/spim_pkg.sv */
`include "spim_consts.svh"
package spim_pkg;
    typedef enum logic [1:0] {SPIM_SZ8, SPIM_SZ16, SPIM_SZ32} spim_size_e;
    typedef enum logic [1:0] {SPIM_LN1, SPIM_LN2, SPIM_LN4} spim_lane_e;
    typedef enum logic [1:0] {SPIM_ST_TXNE, SPIM_ST_RXNF, SPIM_ST_BOTH} spim_start_e;
    typedef enum logic {SPIM_M_IDLE, SPIM_M_WAIT} spim_mst_e;
    typedef enum logic [2:0] {
        SPIM_L_IDLE, SPIM_L_FLOW, SPIM_L_LEAD, SPIM_L_HDR, SPIM_L_DUMMY, SPIM_L_DATA, SPIM_L_LAG
    } spim_lst_e;
endpackage

/* logic/spim_fifo.sv */
module spim_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [AW:0] cap_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [AW:0] level_o
);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0] cnt_reg;
    logic stg_v_reg;
    logic [WIDTH-1:0] stg_d_reg;
    wire push = in_valid_i & in_ready_o;
    wire load = (cnt_reg != '0) & (~stg_v_reg | out_ready_i);

    assign level_o = cnt_reg + {{AW{1'b0}}, stg_v_reg};
    assign in_ready_o = level_o < cap_i;
    assign out_valid_o = stg_v_reg;
    assign out_data_o = stg_d_reg;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wp_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg <= wp_reg + AW'(push);
            rp_reg <= rp_reg + AW'(load);
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(load);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stg_v_reg <= 1'b0;
            stg_d_reg <= '0;
        end else if (load) begin
            stg_v_reg <= 1'b1;
            stg_d_reg <= mem_reg[rp_reg];
        end else if (out_ready_i) begin
            stg_v_reg <= 1'b0;
        end
    end
endmodule // spim_fifo

/* logic/spim_core.sv */
// Summary of operation
// - once the loaded word count runs out, the interrupt outputs stay low.
// - under dma a transfer starts only while words remain, so transfers equal the count.
// - urgent outputs rise when words remain and the tx fifo is nearly empty, or when the rx fifo is nearly full.
// - with flow control on, each word waits for slave ready and rx level under watermark.
// - separate tx and rx dma request outputs allow full duplex dma.
// - single, dual and quad lane modes plus a fast mode with the shortest clock period.
// - memory-mapped reads send read command and address, then return the read word.
// - instruction fetches are served from the serial memory when execute-in-place is on.
// - fifo capacity is eight words at 8 bits, four at 16 bits and two at 32 bits.
// - start condition is tx not empty, rx not full, or both.
// - with dma off, interrupts rise while tx level is below and rx level above the watermark.
// - lead and lag times around slave select are programmable.
`include "spim_consts.svh"
module spim_core import spim_pkg::*; (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic lclk_i,
    input wire logic en_i,
    input wire spim_size_e size_i,
    input wire spim_lane_e lane_i,
    input wire logic fast_i,
    input wire logic rx_dir_i,
    input wire logic [3:0] div_i,
    input wire logic [3:0] lead_i,
    input wire logic [3:0] lag_i,
    input wire spim_start_e start_i,
    input wire logic [3:0] wm_i,
    input wire logic [3:0] urg_wm_i,
    input wire logic fc_en_i,
    input wire logic dma_en_i,
    input wire logic [`SPIM_CNT_W-1:0] wcnt_i,
    input wire logic wcnt_load_i,
    input wire logic tx_valid_i,
    input wire logic [`SPIM_WORD_W-1:0] tx_data_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output logic [`SPIM_WORD_W-1:0] rx_data_o,
    input wire logic rx_ready_i,
    output logic tx_dma_req_o,
    output logic rx_dma_req_o,
    output logic tx_irq_o,
    output logic rx_irq_o,
    output logic tx_urg_o,
    output logic rx_urg_o,
    output logic busy_o,
    output logic done_o,
    input wire logic mm_en_i,
    input wire logic xip_en_i,
    input wire logic mm_req_i,
    input wire logic mm_fetch_i,
    input wire logic [`SPIM_ADDR_W-1:0] mm_addr_i,
    output logic mm_ack_o,
    output logic mm_err_o,
    output logic [`SPIM_WORD_W-1:0] mm_rdata_o,
    output logic sclk_o,
    output logic ssel_n_o,
    output logic [3:0] sd_o,
    output logic [3:0] sd_oe_o,
    input wire logic [3:0] sd_i,
    input wire logic rdy_i
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] f_cap(spim_size_e s);
        unique case (s)
            SPIM_SZ16: f_cap = `SPIM_CAP16;
            SPIM_SZ32: f_cap = `SPIM_CAP32;
            default: f_cap = `SPIM_CAP8;
        endcase
    endfunction

    function automatic logic [5:0] f_bits(spim_size_e s);
        unique case (s)
            SPIM_SZ16: f_bits = `SPIM_BITS16;
            SPIM_SZ32: f_bits = `SPIM_BITS32;
            default: f_bits = `SPIM_BITS8;
        endcase
    endfunction

    function automatic logic [1:0] f_sh(spim_lane_e l);
        unique case (l)
            SPIM_LN2: f_sh = 2'h1;
            SPIM_LN4: f_sh = 2'h2;
            default: f_sh = 2'h0;
        endcase
    endfunction

    function automatic logic [3:0] f_out(logic [31:0] sr, spim_lane_e l);
        unique case (l)
            SPIM_LN2: f_out = {2'h0, sr[31:30]};
            SPIM_LN4: f_out = sr[31:28];
            default: f_out = {3'h0, sr[31]};
        endcase
    endfunction

    function automatic logic [31:0] f_in(logic [31:0] sr, logic [3:0] d, spim_lane_e l);
        unique case (l)
            SPIM_LN2: f_in = {sr[29:0], d[1:0]};
            SPIM_LN4: f_in = {sr[27:0], d};
            default: f_in = {sr[30:0], d[1]};
        endcase
    endfunction

    // ------------------------------------------------------------
    // fifos and system side
    // ------------------------------------------------------------
    spim_mst_e mst_reg;
    logic [`SPIM_CNT_W-1:0] wcnt_reg;
    logic [`SPIM_CNT_W-1:0] txl_reg;
    logic tx_rdy_reg;
    logic tx_dma_reg, rx_dma_reg, tx_irq_reg, rx_irq_reg, tx_urg_reg, rx_urg_reg;
    logic busy_reg, done_reg, mm_ack_reg, mm_err_reg;
    logic [31:0] mm_rdata_reg;
    logic mm_pend_reg, mm_fetch_reg;
    logic [`SPIM_ADDR_W-1:0] mm_addr_reg;
    logic req_tgl_reg, ack_tgl_reg;
    logic ack_s1_reg, ack_s2_reg, ack_s3_reg;
    logic job_mm_reg, job_fc_reg, job_rxd_reg;
    logic [31:0] job_tx_reg;
    logic [5:0] job_bits_reg, job_dum_reg;
    spim_lane_e job_ln_reg;
    logic [4:0] job_half_reg;
    logic [3:0] job_lead_reg, job_lag_reg;
    logic [31:0] res_reg;

    logic tx_f_rdy, tx_out_v, rx_f_rdy;
    logic [31:0] tx_out_d;
    logic [3:0] tx_lvl, rx_lvl;
    wire [3:0] cap = f_cap(size_i);
    wire cnt_live = wcnt_reg != '0;
    wire tx_push = tx_valid_i & tx_rdy_reg & tx_f_rdy;
    wire rx_room = rx_lvl < cap;
    wire start_ok = (start_i == SPIM_ST_TXNE) ? tx_out_v :
                    (start_i == SPIM_ST_RXNF) ? rx_room : tx_out_v & rx_room;
    wire flow_ok = ~fc_en_i | (rx_lvl < wm_i);
    wire mm_allow = mm_fetch_reg ? xip_en_i : mm_en_i;
    wire mm_ok = mm_pend_reg & mm_allow;
    wire mm_bad = mm_pend_reg & ~mm_allow & (mst_reg == SPIM_M_IDLE);
    wire fifo_go = en_i & cnt_live & start_ok & flow_ok & ~mm_pend_reg;
    wire go = (mst_reg == SPIM_M_IDLE) & (mm_ok | fifo_go);
    wire tx_pop = go & ~mm_ok & tx_out_v;
    wire ack_evt = ack_s2_reg ^ ack_s3_reg;
    wire done_evt = ack_evt & (mst_reg == SPIM_M_WAIT);
    wire [5:0] bits_now = f_bits(size_i);
    wire [31:0] tx_word = tx_out_v ? tx_out_d : '0;
    wire [31:0] tx_algn = tx_word << (6'h20 - bits_now);
    wire [31:0] rx_mask = ~(32'hFFFFFFFE << (job_bits_reg - 6'h01));
    wire rx_push = done_evt & ~job_mm_reg & rx_f_rdy;
    wire [7:0] mm_cmd = (lane_i == SPIM_LN4) ? `SPIM_CMD_QUAD :
                        (lane_i == SPIM_LN2) ? `SPIM_CMD_DUAL :
                        fast_i ? `SPIM_CMD_FAST : `SPIM_CMD_RD;
    wire mm_dum = fast_i | (lane_i != SPIM_LN1);
    wire [4:0] half_now = `SPIM_HALF_MIN + (fast_i ? 5'h00 : {1'b0, div_i});
    wire [3:0] tx_nxt = tx_push ? tx_lvl + 4'h2 : tx_lvl + 4'h1;

    spim_fifo #(.WIDTH(`SPIM_WORD_W), .DEPTH(`SPIM_FIFO_DEPTH), .AW(`SPIM_FIFO_AW)) u_txf (
        .clk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .cap_i(cap),
        .in_valid_i(tx_push),
        .in_ready_o(tx_f_rdy),
        .in_data_i(tx_data_i),
        .out_valid_o(tx_out_v),
        .out_ready_i(tx_pop),
        .out_data_o(tx_out_d),
        .level_o(tx_lvl)
    );

    spim_fifo #(.WIDTH(`SPIM_WORD_W), .DEPTH(`SPIM_FIFO_DEPTH), .AW(`SPIM_FIFO_AW)) u_rxf (
        .clk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .cap_i(cap),
        .in_valid_i(rx_push),
        .in_ready_o(rx_f_rdy),
        .in_data_i(res_reg & rx_mask),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i),
        .out_data_o(rx_data_o),
        .level_o(rx_lvl)
    );

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
            ack_s3_reg <= 1'b0;
        end else begin
            ack_s1_reg <= ack_tgl_reg;
            ack_s2_reg <= ack_s1_reg;
            ack_s3_reg <= ack_s2_reg;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wcnt_reg <= '0;
            txl_reg <= '0;
        end else if (wcnt_load_i) begin
            wcnt_reg <= wcnt_i;
            txl_reg <= wcnt_i;
        end else begin
            if (done_evt & ~job_mm_reg) wcnt_reg <= wcnt_reg - 16'h0001;
            if (tx_push & (txl_reg != '0)) txl_reg <= txl_reg - 16'h0001;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mm_pend_reg <= 1'b0;
            mm_fetch_reg <= 1'b0;
            mm_addr_reg <= '0;
        end else if (!mm_pend_reg) begin
            mm_pend_reg <= mm_req_i;
            mm_fetch_reg <= mm_fetch_i;
            mm_addr_reg <= mm_addr_i;
        end else if ((go & mm_ok) | mm_bad) begin
            mm_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mst_reg <= SPIM_M_IDLE;
            req_tgl_reg <= 1'b0;
        end else if (go) begin
            mst_reg <= SPIM_M_WAIT;
            req_tgl_reg <= ~req_tgl_reg;
        end else if (done_evt) begin
            mst_reg <= SPIM_M_IDLE;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            job_mm_reg <= 1'b0;
            job_fc_reg <= 1'b0;
            job_rxd_reg <= 1'b0;
            job_tx_reg <= '0;
            job_bits_reg <= `SPIM_BITS8;
            job_dum_reg <= '0;
            job_ln_reg <= SPIM_LN1;
            job_half_reg <= `SPIM_HALF_MIN;
            job_lead_reg <= '0;
            job_lag_reg <= '0;
        end else if (go) begin
            job_mm_reg <= mm_ok;
            job_fc_reg <= fc_en_i & ~mm_ok;
            job_rxd_reg <= rx_dir_i | mm_ok;
            job_tx_reg <= mm_ok ? {mm_cmd, mm_addr_reg} : tx_algn;
            job_bits_reg <= mm_ok ? `SPIM_BITS32 : bits_now;
            job_dum_reg <= (mm_ok & mm_dum) ? `SPIM_DUMMY_CLKS : 6'h00;
            job_ln_reg <= lane_i;
            job_half_reg <= half_now;
            job_lead_reg <= lead_i;
            job_lag_reg <= lag_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mm_ack_reg <= 1'b0;
            mm_err_reg <= 1'b0;
            mm_rdata_reg <= '0;
        end else begin
            mm_ack_reg <= done_evt & job_mm_reg;
            mm_err_reg <= mm_bad;
            if (done_evt & job_mm_reg) mm_rdata_reg <= res_reg;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_rdy_reg <= 1'b0;
            tx_dma_reg <= 1'b0;
            rx_dma_reg <= 1'b0;
            tx_irq_reg <= 1'b0;
            rx_irq_reg <= 1'b0;
            tx_urg_reg <= 1'b0;
            rx_urg_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
        end else begin
            tx_rdy_reg <= en_i & (tx_nxt <= cap);
            tx_dma_reg <= dma_en_i & cnt_live & (txl_reg != '0) & (tx_lvl < wm_i);
            rx_dma_reg <= dma_en_i & ((rx_lvl > wm_i) | (~cnt_live & rx_valid_o));
            tx_irq_reg <= ~dma_en_i & cnt_live & (tx_lvl < wm_i);
            rx_irq_reg <= ~dma_en_i & cnt_live & (rx_lvl > wm_i);
            tx_urg_reg <= cnt_live & (tx_lvl < urg_wm_i);
            rx_urg_reg <= ({1'b0, rx_lvl} + {1'b0, urg_wm_i}) > {1'b0, cap};
            busy_reg <= (mst_reg == SPIM_M_WAIT) | go;
            done_reg <= ~cnt_live;
        end
    end

    assign tx_ready_o = tx_rdy_reg;
    assign tx_dma_req_o = tx_dma_reg;
    assign rx_dma_req_o = rx_dma_reg;
    assign tx_irq_o = tx_irq_reg;
    assign rx_irq_o = rx_irq_reg;
    assign tx_urg_o = tx_urg_reg;
    assign rx_urg_o = rx_urg_reg;
    assign busy_o = busy_reg;
    assign done_o = done_reg;
    assign mm_ack_o = mm_ack_reg;
    assign mm_err_o = mm_err_reg;
    assign mm_rdata_o = mm_rdata_reg;

    // ------------------------------------------------------------
    // link side engine
    // ------------------------------------------------------------
    spim_lst_e lst_reg;
    logic rq_s1_reg, rq_s2_reg, rq_s3_reg;
    logic [3:0] sd_s1_reg, sd_s2_reg;
    logic rdy_s1_reg, rdy_s2_reg;
    logic [4:0] hcnt_reg;
    logic [5:0] ccnt_reg;
    logic [31:0] tx_sr_reg, rx_sr_reg;
    logic sclk_reg, ssn_reg;
    logic [3:0] sd_reg, oe_reg;

    wire req_evt = rq_s2_reg ^ rq_s3_reg;
    wire go_lead = ((lst_reg == SPIM_L_IDLE) & req_evt & ~job_fc_reg) |
                   ((lst_reg == SPIM_L_FLOW) & rdy_s2_reg);
    wire shifting = (lst_reg == SPIM_L_HDR) | (lst_reg == SPIM_L_DUMMY) |
                    (lst_reg == SPIM_L_DATA);
    wire hz = hcnt_reg == 5'h00;
    wire fall = shifting & hz & sclk_reg;
    wire last = fall & (ccnt_reg == 6'h01);
    wire spim_lane_e eff_ln = (lst_reg == SPIM_L_HDR) ? SPIM_LN1 : job_ln_reg;
    wire spim_lane_e first_ln = job_mm_reg ? SPIM_LN1 : job_ln_reg;
    wire [31:0] tx_shl = tx_sr_reg << ({3'h0, f_sh(eff_ln)} + 5'h01);
    wire [5:0] dat_clks = job_bits_reg >> f_sh(job_ln_reg);
    wire drive = ~(job_rxd_reg & (job_ln_reg != SPIM_LN1));
    wire [3:0] dat_oe = ~drive ? 4'h0 : (job_ln_reg == SPIM_LN4) ? `SPIM_OE_4 :
                        (job_ln_reg == SPIM_LN2) ? `SPIM_OE_2 : `SPIM_OE_1;
    wire [4:0] half_m1 = job_half_reg - 5'h01;

    always_ff @(posedge lclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rq_s1_reg <= 1'b0;
            rq_s2_reg <= 1'b0;
            rq_s3_reg <= 1'b0;
            sd_s1_reg <= '0;
            sd_s2_reg <= '0;
            rdy_s1_reg <= 1'b0;
            rdy_s2_reg <= 1'b0;
        end else begin
            rq_s1_reg <= req_tgl_reg;
            rq_s2_reg <= rq_s1_reg;
            rq_s3_reg <= rq_s2_reg;
            sd_s1_reg <= sd_i;
            sd_s2_reg <= sd_s1_reg;
            rdy_s1_reg <= rdy_i;
            rdy_s2_reg <= rdy_s1_reg;
        end
    end

    always_ff @(posedge lclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lst_reg <= SPIM_L_IDLE;
            hcnt_reg <= '0;
            ccnt_reg <= '0;
            tx_sr_reg <= '0;
            rx_sr_reg <= '0;
            sclk_reg <= 1'b0;
            ssn_reg <= 1'b1;
            sd_reg <= '0;
            oe_reg <= '0;
            ack_tgl_reg <= 1'b0;
            res_reg <= '0;
        end else if (go_lead) begin
            lst_reg <= SPIM_L_LEAD;
            ssn_reg <= 1'b0;
            hcnt_reg <= {1'b0, job_lead_reg};
            tx_sr_reg <= job_tx_reg;
            rx_sr_reg <= '0;
            sd_reg <= f_out(job_tx_reg, first_ln);
            oe_reg <= job_mm_reg ? `SPIM_OE_1 : dat_oe;
        end else begin
            unique case (lst_reg)
                SPIM_L_IDLE: begin
                    if (req_evt) lst_reg <= SPIM_L_FLOW;
                end
                SPIM_L_FLOW: begin end
                SPIM_L_LEAD: begin
                    hcnt_reg <= hz ? half_m1 : hcnt_reg - 5'h01;
                    if (hz) begin
                        lst_reg <= job_mm_reg ? SPIM_L_HDR : SPIM_L_DATA;
                        ccnt_reg <= job_mm_reg ? `SPIM_HDR_CLKS : dat_clks;
                    end
                end
                SPIM_L_HDR, SPIM_L_DUMMY, SPIM_L_DATA: begin
                    hcnt_reg <= hz ? half_m1 : hcnt_reg - 5'h01;
                    if (hz) sclk_reg <= ~sclk_reg;
                    if (fall) begin
                        ccnt_reg <= ccnt_reg - 6'h01;
                        if (lst_reg == SPIM_L_DATA) rx_sr_reg <= f_in(rx_sr_reg, sd_s2_reg, eff_ln);
                        if (lst_reg != SPIM_L_DUMMY) begin
                            tx_sr_reg <= tx_shl;
                            sd_reg <= f_out(tx_shl, eff_ln);
                        end
                    end
                    if (last) begin
                        if ((lst_reg == SPIM_L_HDR) && (job_dum_reg != '0)) begin
                            lst_reg <= SPIM_L_DUMMY;
                            ccnt_reg <= job_dum_reg;
                        end else if (lst_reg != SPIM_L_DATA) begin
                            lst_reg <= SPIM_L_DATA;
                            ccnt_reg <= dat_clks;
                            oe_reg <= dat_oe;
                        end else begin
                            lst_reg <= SPIM_L_LAG;
                            hcnt_reg <= {1'b0, job_lag_reg};
                        end
                    end
                end
                SPIM_L_LAG: begin
                    hcnt_reg <= hcnt_reg - 5'h01;
                    if (hz) begin
                        lst_reg <= SPIM_L_IDLE;
                        ssn_reg <= 1'b1;
                        sd_reg <= '0;
                        oe_reg <= '0;
                        res_reg <= rx_sr_reg;
                        ack_tgl_reg <= ~ack_tgl_reg;
                    end
                end
                default: lst_reg <= SPIM_L_IDLE;
            endcase
        end
    end

    assign sclk_o = sclk_reg;
    assign ssel_n_o = ssn_reg;
    assign sd_o = sd_reg;
    assign sd_oe_o = oe_reg;
endmodule // spim_core

/* test/spim_core_assertions.sv */
`include "spim_consts.svh"
// ----------------------------------------
// port checks for the core
// ----------------------------------------
module spim_core_assertions (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic lclk_i,
    input wire logic en_i,
    input wire logic dma_en_i,
    input wire logic [`SPIM_CNT_W-1:0] wcnt_i,
    input wire logic wcnt_load_i,
    input wire logic tx_ready_o,
    input wire logic tx_dma_req_o,
    input wire logic rx_dma_req_o,
    input wire logic tx_irq_o,
    input wire logic rx_irq_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic mm_en_i,
    input wire logic mm_req_i,
    input wire logic mm_fetch_i,
    input wire logic mm_ack_o,
    input wire logic mm_err_o,
    input wire logic sclk_o,
    input wire logic ssel_n_o
);
    AST_LOAD_DONE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        wcnt_load_i && wcnt_i != '0 |-> ##2 !done_o) else $error("load left done set");
    AST_IRQ_STOP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        done_o && $past(done_o) |-> !tx_irq_o && !rx_irq_o) else $error("irq after count end");
    AST_TXDMA_END: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        done_o && $past(done_o) |-> !tx_dma_req_o) else $error("tx dma after count end");
    AST_DMA_OFF: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !dma_en_i && !$past(dma_en_i) |-> !tx_dma_req_o && !rx_dma_req_o)
        else $error("dma req with dma off");
    AST_ERR_REFUSE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        mm_req_i && !mm_fetch_i && !mm_en_i && !busy_o |-> ##2 mm_err_o && !mm_ack_o)
        else $error("no refusal error");
    AST_MM_PULSE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        mm_ack_o || mm_err_o |=> !mm_ack_o && !mm_err_o) else $error("mm answer too long");
    AST_EN_READY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !en_i && !$past(en_i) |-> !tx_ready_o) else $error("tx ready while disabled");
    AST_SCLK_IDLE: assert property (@(posedge lclk_i) disable iff (!rst_n_i)
        ssel_n_o |-> !sclk_o) else $error("sclk high deselected");
    COV_ACK: cover property (@(posedge mclk_i) mm_ack_o);
    COV_ERR: cover property (@(posedge mclk_i) mm_err_o);
    COV_TXDMA: cover property (@(posedge mclk_i) tx_dma_req_o);
endmodule // spim_core_assertions

bind spim_core spim_core_assertions i_chk (.mclk_i, .rst_n_i, .lclk_i, .en_i, .dma_en_i,
    .wcnt_i, .wcnt_load_i, .tx_ready_o, .tx_dma_req_o, .rx_dma_req_o, .tx_irq_o, .rx_irq_o,
    .busy_o, .done_o, .mm_en_i, .mm_req_i, .mm_fetch_i, .mm_ack_o, .mm_err_o, .sclk_o,
    .ssel_n_o);

/* test/spim_flash_model.sv */
// ----------------------------------------
// serial memory / slave model, mode 0
// ----------------------------------------
module spim_flash_model #(
    parameter logic [63:0] PAT = 64'hC3A5_1E7D_9B24_F068
) (
    input wire logic sclk_i,
    input wire logic ssel_n_i,
    input wire logic [3:0] bus_i,
    input wire logic [3:0] oe_i,
    input wire logic stall_i,
    output logic [3:0] bus_o,
    output logic rdy_o,
    output logic [7:0] first_byte_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] cnt = 7'h00;
    wire out_bit = ssel_n_i ? ~PAT[63] : PAT[6'h3F - cnt[5:0]];
    assign rdy_o = ~stall_i;
    assign bus_o = (oe_i & bus_i) | (~oe_i & {4{out_bit}});
    always @(negedge sclk_i or posedge ssel_n_i) begin
        if (ssel_n_i !== 1'h0) cnt <= 7'h00;
        else cnt <= cnt + 7'h01;
    end
    always @(posedge sclk_i) if (cnt < 7'h08) first_byte_o <= {first_byte_o[6:0], bus_i[0]};
endmodule // spim_flash_model

/* test/tb.sv */
module tb import spim_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
    $display("mismatch at %0t: got %h exp %h", $time, a, e); end end
    localparam logic [63:0] PAT = 64'hC3A5_1E7D_9B24_F068;
    int errors = 0, check_count = 0;
    logic mclk_i = 1'h0, lclk_i = 1'h0, rst_n_i = 1'h0, en_i = 1'h1, fast_i = 1'h0;
    logic rx_dir_i = 1'h0, fc_en_i = 1'h0, dma_en_i = 1'h0, wcnt_load_i = 1'h0, stall = 1'h0;
    logic tx_valid_i = 1'h0, rx_ready_i = 1'h0, xip_en_i = 1'h0, mm_en_i = 1'h0;
    logic mm_req_i = 1'h0, mm_fetch_i = 1'h0, rdy_i;
    spim_size_e size_i = SPIM_SZ8;
    spim_lane_e lane_i = SPIM_LN1;
    spim_start_e start_i = SPIM_ST_TXNE;
    logic [3:0] div_i = 4'h2, lead_i = 4'h1, lag_i = 4'h1, wm_i = 4'h1, urg_wm_i = 4'h1;
    logic [15:0] wcnt_i = 16'h0000;
    logic [31:0] tx_data_i = 32'h0, rx_data_o, mm_rdata_o;
    logic [23:0] mm_addr_i = 24'h0;
    logic [3:0] sd_i, sd_o, sd_oe_o;
    logic [7:0] first_byte;
    logic tx_ready_o, rx_valid_o, tx_dma_req_o, rx_dma_req_o, tx_irq_o, rx_irq_o, tx_urg_o;
    logic rx_urg_o, busy_o, done_o, mm_ack_o, mm_err_o, sclk_o, ssel_n_o;
    initial forever #25 mclk_i = ~mclk_i;
    initial begin
        #7;
        forever #80 lclk_i = ~lclk_i;
    end
    spim_core i_dut (.mclk_i, .rst_n_i, .lclk_i, .en_i, .size_i, .lane_i, .fast_i, .rx_dir_i,
        .div_i, .lead_i, .lag_i, .start_i, .wm_i, .urg_wm_i, .fc_en_i, .dma_en_i, .wcnt_i,
        .wcnt_load_i, .tx_valid_i, .tx_data_i, .tx_ready_o, .rx_valid_o, .rx_data_o,
        .rx_ready_i, .tx_dma_req_o, .rx_dma_req_o, .tx_irq_o, .rx_irq_o, .tx_urg_o, .rx_urg_o,
        .busy_o, .done_o, .mm_en_i, .xip_en_i, .mm_req_i, .mm_fetch_i, .mm_addr_i, .mm_ack_o,
        .mm_err_o, .mm_rdata_o, .sclk_o, .ssel_n_o, .sd_o, .sd_oe_o, .sd_i, .rdy_i);
    spim_flash_model #(.PAT(PAT)) i_mem (.sclk_i(sclk_o), .ssel_n_i(ssel_n_o), .bus_i(sd_o),
        .oe_i(sd_oe_o), .stall_i(stall), .bus_o(sd_i), .rdy_o(rdy_i), .first_byte_o(first_byte));
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic load(input logic [15:0] n);
        step(1);
        wcnt_load_i <= 1'h1;
        wcnt_i <= n;
        step(1);
        wcnt_load_i <= 1'h0;
    endtask
    task automatic push(input logic [31:0] d);
        step(1);
        tx_valid_i <= 1'h1;
        tx_data_i <= d;
        do @(negedge mclk_i); while (tx_ready_o !== 1'h1);
        step(1);
        tx_valid_i <= 1'h0;
    endtask
    task automatic pop(input logic [31:0] e);
        step(1);
        rx_ready_i <= 1'h1;
        do @(negedge mclk_i); while (rx_valid_o !== 1'h1);
        `CHK(rx_data_o, e)
        step(1);
        rx_ready_i <= 1'h0;
    endtask
    task automatic wait_done();
        for (int i = 0; i < 5000 && done_o !== 1'h1; i++) @(negedge mclk_i);
        `CHK(done_o, 1'h1)
    endtask
    task automatic mm_read(input logic f, input logic ok, input logic [39:0] e);
        step(1);
        mm_req_i <= 1'h1;
        mm_fetch_i <= f;
        mm_addr_i <= 24'h12_3450;
        step(1);
        mm_req_i <= 1'h0;
        for (int i = 0; i < 5000 && !mm_ack_o && !mm_err_o; i++) @(negedge mclk_i);
        `CHK({mm_ack_o, mm_err_o}, {ok, ~ok})
        if (ok) `CHK({mm_rdata_o, first_byte}, e)
        step(1);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        step(5);
        rst_n_i <= 1'h1;
        step(2);
        `CHK({done_o, ssel_n_o, tx_irq_o}, 3'h6)
        load(16'h0002);
        step(3);
        `CHK(tx_irq_o, 1'h1)
        `CHK({tx_urg_o, rx_urg_o, busy_o}, 3'h4)
        push(32'hA5);
        push(32'h3C);
        wait_done();
        step(4);
        `CHK({tx_irq_o, rx_irq_o, first_byte}, {2'h0, 8'h3C})
        pop({24'h0, PAT[63:56]});
        pop({24'h0, PAT[63:56]});
        $display("test single done");
        en_i <= 1'h0;
        mm_en_i <= 1'h1;
        step(3);
        `CHK(tx_ready_o, 1'h0)
        mm_read(1'h0, 1'h1, {PAT[31:0], 8'h03});
        mm_en_i <= 1'h0;
        xip_en_i <= 1'h1;
        fast_i <= 1'h1;
        mm_read(1'h1, 1'h1, {PAT[23:0], PAT[63:56], 8'h0B});
        mm_read(1'h0, 1'h0, 40'h0);
        $display("test memory done");
        en_i <= 1'h1;
        dma_en_i <= 1'h1;
        size_i <= SPIM_SZ32;
        start_i <= SPIM_ST_BOTH;
        fc_en_i <= 1'h1;
        wm_i <= 4'h2;
        lead_i <= 4'h3;
        stall <= 1'h1;
        load(16'h0003);
        step(3);
        `CHK({tx_dma_req_o, tx_irq_o}, 2'h2)
        fork
            for (int k = 0; k < 3; k++) push(32'hBEEF_0000 + k);
            for (int k = 0; k < 3; k++) pop(PAT[63:32]);
            begin
                step(100);
                `CHK(ssel_n_o, 1'h1)
                stall <= 1'h0;
            end
        join
        wait_done();
        step(6);
        `CHK({tx_dma_req_o, rx_dma_req_o, ssel_n_o, rx_valid_o}, 4'h2)
        $display("test dma done");
        wrap_up();
    end
    initial begin
        step(30000);
        errors++;
        wrap_up();
    end
endmodule // tb
